// >>> shared/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  localparam int RES_W        = 10;
  localparam int CMP_W        = 8;
  localparam int NIB_W        = 4;
  localparam int CTRL_W       = 4;
  localparam int CTRL_MODE    = 3;
  localparam int SEL_W        = 2;
  localparam int CONV_CYCLES  = 62;
  localparam int CMP_CYCLES   = 8;
  localparam int MC_DIV       = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [RES_W-1:0]  RES_CLEAR  = 10'h000;
  localparam logic [CMP_W-1:0]  CMP_RESET  = 8'h00;
  localparam logic [7:0]        CNT_ZERO   = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_CMP  = 2'b10
  } adc_state_t;

  typedef struct packed {
    logic start_conversion_op;
    logic load_compare_value_op;
    logic move_result_high_op;
    logic move_result_low_op;
    logic skip_if_done_op;
    logic ctrl_write;
    logic ctrl_read;
    logic irq_taken;
  } op_t;

  typedef struct packed {
    logic [NIB_W-1:0] acc_a;
    logic [NIB_W-1:0] acc_b;
  } acc_t;
endpackage : adc_ctrl_pkg

// >>> rtl/mcycle_tick.sv
`timescale 1ns/1ps
module mcycle_tick
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = MC_DIV
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = CNT_ZERO;
    end else if (cnt == 8'(DIV - 1)) begin
      next_cnt  = CNT_ZERO;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= CNT_ZERO;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : mcycle_tick

// >>> rtl/in_sync.sv
`timescale 1ns/1ps
module in_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : in_sync

// >>> rtl/sar_adc_and_comparator_ctrl.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Start op runs selected mode, stores result
// - Conversion start clears result, then sets MSB for first trial
// - Trial bit set, kept if DAC below
// - Trials go MSB to LSB, ten total
// - Conversion finishes after 62 machine cycles
// - Completion sets done flag, and request when interrupt chosen
// - Mode bit one selects comparator mode
// - Compare value loaded from B high, A low
// - Compare value separate, kept across modes
// - Compare value access only in comparator mode
// - Comparator mode DAC code is compare value
// - Comparison lasts 8 cycles, flag if below
// - Flag cleared by interrupt or taken skip
// - Irq control selects interrupt or skip
// - Move-low puts two LSBs atop A
// - Move-high puts eight MSBs in A,B
// - Analog pins keep port output function
// - Low bits select input, bit2 spare
// - Mode bit zero selects conversion mode
module sar_adc_and_comparator_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_MC = CONV_CYCLES,
  parameter int CMP_MC  = CMP_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire op_t                op,
  input  wire acc_t               acc_in,
  input  wire logic [CTRL_W-1:0]  ctrl_wdata,
  input  wire logic               skip_mode_sel,
  input  wire logic               comparator_out,
  output logic [CTRL_W-1:0]       ctrl_rdata,
  output acc_t                    acc_out,
  output logic                    acc_out_valid,
  output logic [RES_W-1:0]        dac_code,
  output logic [SEL_W-1:0]        analog_input_sel,
  output logic                    conversion_done_flag,
  output logic                    adc_irq_req,
  output logic                    skip_taken,
  output logic                    busy
);
  localparam logic [7:0] CONV_LAST = 8'(CONV_MC - 1);
  localparam logic [7:0] CMP_LAST  = 8'(CMP_MC - 1);
  localparam logic [7:0] TRIAL_MC  = 8'(CONV_MC / RES_W);
  localparam int         LOW_W     = RES_W - CMP_W;
  // Index left after the last trial; no bit is tried past it
  localparam logic [3:0] BIT_NONE  = 4'hF;

  adc_state_t         state;
  adc_state_t         next_state;
  logic [CTRL_W-1:0]  converter_control_reg;
  logic [CTRL_W-1:0]  next_ctrl;
  logic [RES_W-1:0]   result;
  logic [RES_W-1:0]   next_result;
  logic [CMP_W-1:0]   compare_value;
  logic [CMP_W-1:0]   next_compare_value;
  logic [7:0]         mc_cnt;
  logic [7:0]         next_mc_cnt;
  logic [3:0]         bit_idx;
  logic [3:0]         next_bit_idx;
  logic [7:0]         trial_cnt;
  logic [7:0]         next_trial_cnt;
  logic               next_flag;
  logic               next_skip;
  acc_t               next_acc_out;
  logic               next_acc_valid;
  logic [CTRL_W-1:0]  next_ctrl_rdata;
  logic               dac_below;
  logic               tick;
  logic               cmp_mode;
  logic               set_flag;

  // Comparator output is asynchronous to clk
  in_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (comparator_out),
    .q     (dac_below)
  );

  // A start refused while busy must not stretch the running count
  mcycle_tick #(.DIV(MC_DIV)) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (op.start_conversion_op & ~busy),
    .tick    (tick)
  );

  assign cmp_mode         = converter_control_reg[CTRL_MODE];
  assign analog_input_sel = converter_control_reg[SEL_W-1:0];
  assign busy             = (state != ST_IDLE);
  // Flag raises request only when interrupt servicing chosen
  assign adc_irq_req      = conversion_done_flag & ~skip_mode_sel;

  // DAC follows the trial register or the compare value
  always_comb begin
    if (cmp_mode) begin
      dac_code = {compare_value, {LOW_W{1'b0}}};
    end else begin
      dac_code = result;
    end
  end

  // Accumulator pair from an 8-bit value, high nibble into B
  function automatic acc_t to_acc(input logic [CMP_W-1:0] v);
    acc_t a;
    a.acc_b = v[CMP_W-1:NIB_W];
    a.acc_a = v[NIB_W-1:0];
    return a;
  endfunction : to_acc

  // One trial step: keep or drop the tried bit, then try the next lower
  function automatic logic [RES_W-1:0] trial_step(
    input logic [RES_W-1:0] r,
    input logic [3:0]       idx,
    input logic             keep
  );
    logic [RES_W-1:0] n;
    n      = r;
    n[idx] = keep;
    if (idx != 4'h0) begin
      n[idx - 4'h1] = 1'b1;
    end
    return n;
  endfunction : trial_step

  // Compares a cycle counter with its last value
  function automatic logic count_done(
    input logic [7:0] cnt,
    input logic [7:0] last
  );
    return cnt == last;
  endfunction : count_done

  // Control register and its read-back copy
  always_comb begin
    next_ctrl       = converter_control_reg;
    next_ctrl_rdata = ctrl_rdata;
    // Mode change while busy is the software's fault; not guarded
    if (op.ctrl_write) begin
      next_ctrl = ctrl_wdata;
    end
    // Read-back is registered, so it stands until the next read
    if (op.ctrl_read) begin
      next_ctrl_rdata = converter_control_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_control_reg <= CTRL_RESET;
      ctrl_rdata            <= CTRL_RESET;
    end else begin
      converter_control_reg <= next_ctrl;
      ctrl_rdata            <= next_ctrl_rdata;
    end
  end

  // Compare value and accumulator transfers
  always_comb begin
    next_compare_value = compare_value;
    next_acc_out       = acc_out;
    next_acc_valid     = 1'b0;
    // A stray load in conversion mode cannot move the reference
    if (op.load_compare_value_op && cmp_mode) begin
      next_compare_value = {acc_in.acc_b, acc_in.acc_a};
    end
    // Moved values stand until the next move; valid marks one cycle
    if (op.move_result_high_op) begin
      if (cmp_mode) begin
        next_acc_out = to_acc(compare_value);
      end else begin
        next_acc_out = to_acc(result[RES_W-1 -: CMP_W]);
      end
      next_acc_valid = 1'b1;
    end
    if (op.move_result_low_op) begin
      next_acc_out.acc_a = {result[LOW_W-1:0], {(NIB_W-LOW_W){1'b0}}};
      next_acc_out.acc_b = acc_in.acc_b;
      next_acc_valid     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_value <= CMP_RESET;
      acc_out       <= '0;
      acc_out_valid <= 1'b0;
    end else begin
      compare_value <= next_compare_value;
      acc_out       <= next_acc_out;
      acc_out_valid <= next_acc_valid;
    end
  end

  // Completion flag; a completion beats a clear in the same cycle
  always_comb begin
    next_flag = conversion_done_flag;
    next_skip = 1'b0;
    // Interrupt acceptance only clears when interrupt servicing is chosen
    if (op.irq_taken && !skip_mode_sel) begin
      next_flag = 1'b0;
    end
    if (op.skip_if_done_op && conversion_done_flag) begin
      next_flag = 1'b0;
      next_skip = 1'b1;
    end
    if (set_flag) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
      skip_taken           <= 1'b0;
    end else begin
      conversion_done_flag <= next_flag;
      skip_taken           <= next_skip;
    end
  end

  // Sequencer, trial register and machine-cycle counters
  always_comb begin
    next_state     = state;
    next_result    = result;
    next_mc_cnt    = mc_cnt;
    next_bit_idx   = bit_idx;
    next_trial_cnt = trial_cnt;
    set_flag       = 1'b0;
    case (state)
      ST_IDLE: begin
        // A start while busy lands outside this state and is dropped
        if (op.start_conversion_op) begin
          next_mc_cnt    = CNT_ZERO;
          next_trial_cnt = CNT_ZERO;
          if (cmp_mode) begin
            next_state = ST_CMP;
          end else begin
            next_state   = ST_CONV;
            next_bit_idx = 4'(RES_W - 1);
            next_result  = RES_CLEAR;
            next_result[RES_W-1] = 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          next_mc_cnt    = mc_cnt + 8'h01;
          next_trial_cnt = trial_cnt + 8'h01;
          // Late trial cycles let the synchronised comparator settle
          if (count_done(trial_cnt, TRIAL_MC - 8'h01)
              && bit_idx != BIT_NONE) begin
            next_trial_cnt = CNT_ZERO;
            next_result    = trial_step(result, bit_idx, dac_below);
            next_bit_idx   = bit_idx - 4'h1;
          end
          if (count_done(mc_cnt, CONV_LAST)) begin
            next_state = ST_IDLE;
            set_flag   = 1'b1;
          end
        end
      end
      ST_CMP: begin
        if (tick) begin
          next_mc_cnt = mc_cnt + 8'h01;
          if (count_done(mc_cnt, CMP_LAST)) begin
            next_state = ST_IDLE;
            // Input below reference drives comparator low
            if (dac_below == 1'b0) begin
              set_flag = 1'b1;
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      result    <= RES_CLEAR;
      mc_cnt    <= CNT_ZERO;
      bit_idx   <= 4'h0;
      trial_cnt <= CNT_ZERO;
    end else begin
      state     <= next_state;
      result    <= next_result;
      mc_cnt    <= next_mc_cnt;
      bit_idx   <= next_bit_idx;
      trial_cnt <= next_trial_cnt;
    end
  end
  // Analog pins stay ports; the port block drives them high
endmodule : sar_adc_and_comparator_ctrl

// >>> test/sar_ctrl_checker.sv
`timescale 1ns/1ps
module sar_ctrl_checker
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_MC = CONV_CYCLES,
  parameter int CMP_MC  = CMP_CYCLES
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire op_t              op,
  input wire acc_t             acc_in,
  input wire logic [CTRL_W-1:0] ctrl_wdata,
  input wire logic             skip_mode_sel,
  input wire acc_t             acc_out,
  input wire logic             acc_out_valid,
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [SEL_W-1:0] analog_input_sel,
  input wire logic             conversion_done_flag,
  input wire logic             adc_irq_req,
  input wire logic             skip_taken,
  input wire logic             busy
);
  logic mode;
  logic go;
  // Mode mirror; writes while busy are the software's fault, not tracked
  always_ff @(posedge clk) begin
    if (!rst_n) mode <= 1'b0;
    else if (op.ctrl_write && !busy) mode <= ctrl_wdata[CTRL_MODE];
  end
  assign go = op.start_conversion_op && !busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Start edge plus one tick per machine cycle
  localparam int CONV_END = CONV_MC + 1;
  localparam int CMP_END  = CMP_MC + 1;
  sequence s_conv;
    ##CONV_END busy ##1 (!busy && conversion_done_flag);
  endsequence
  sequence s_cmp;
    ##CMP_END busy ##1 !busy;
  endsequence
  a_conv_time: assert property (
    go && !mode |-> s_conv) else $error("conversion length wrong");
  a_cmp_time: assert property (
    go && mode |-> s_cmp) else $error("comparison length wrong");
  a_conv_clear: assert property (
    go && !mode |=> dac_code == 10'h200) else $error("first trial wrong");
  a_dac_cmp: assert property (
    op.load_compare_value_op && mode |=>
    dac_code == {$past(acc_in.acc_b), $past(acc_in.acc_a), 2'h0})
    else $error("dac code wrong");
  a_irq_req: assert property (
    adc_irq_req == (conversion_done_flag && !skip_mode_sel))
    else $error("request wrong");
  a_skip_clear: assert property (
    op.skip_if_done_op && conversion_done_flag && !busy
    |=> skip_taken && !conversion_done_flag) else $error("skip wrong");
  a_move_low: assert property (
    op.move_result_low_op |=> acc_out_valid && acc_out.acc_a[1:0] == 2'h0
    && acc_out.acc_b == $past(acc_in.acc_b)) else $error("move low wrong");
  a_sel_write: assert property (
    op.ctrl_write && !busy |=> analog_input_sel == $past(ctrl_wdata[1:0]))
    else $error("select wrong");
  a_result_hold: assert property (
    !mode && !busy && !op.start_conversion_op && !op.ctrl_write
    |=> $stable(dac_code)) else $error("result moved");
endmodule : sar_ctrl_checker

bind sar_adc_and_comparator_ctrl sar_ctrl_checker #(
  .CONV_MC(CONV_MC), .CMP_MC(CMP_MC)) i_chk (
  .clk(clk), .rst_n(rst_n), .op(op), .acc_in(acc_in),
  .ctrl_wdata(ctrl_wdata), .skip_mode_sel(skip_mode_sel),
  .acc_out(acc_out), .acc_out_valid(acc_out_valid), .dac_code(dac_code),
  .analog_input_sel(analog_input_sel), .busy(busy),
  .conversion_done_flag(conversion_done_flag),
  .adc_irq_req(adc_irq_req), .skip_taken(skip_taken));

// >>> test/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model
  import adc_ctrl_pkg::*;
(
  input wire logic [10:0]      analog_input_voltage [4],
  input wire logic [SEL_W-1:0] sel,
  input wire logic [RES_W-1:0] dac_code,
  output logic                 comparator_out
);
  // Ideal comparator; 11-bit input lets a level sit above full scale
  assign comparator_out = ({1'b0, dac_code} < analog_input_voltage[sel]);
endmodule : analog_front_model

// >>> test/sar_adc_and_comparator_ctrl_test.sv
`timescale 1ns/1ps
module sar_adc_and_comparator_ctrl_test;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [10:0] analog_input_voltage;
    logic [9:0]  res;
  } row_t;
  localparam row_t ROWS [6] = '{'{4'h0, 11'h000, 10'h000},
    '{4'h1, 11'h001, 10'h000}, '{4'h6, 11'h200, 10'h1FF},
    '{4'h3, 11'h201, 10'h200}, '{4'h7, 11'h400, 10'h3FF},
    '{4'h2, 11'h155, 10'h154}};
  localparam op_t OP_ST = 8'h80, OP_LD = 8'h40, OP_HI = 8'h20;
  localparam op_t OP_LO = 8'h10, OP_SK = 8'h08, OP_WR = 8'h04;
  localparam op_t OP_RD = 8'h02, OP_IQ = 8'h01;
  logic clk, rst_n, skip_mode_sel, comparator_out, acc_out_valid;
  logic conversion_done_flag, adc_irq_req, skip_taken, busy;
  op_t op;
  acc_t acc_in, acc_out, hi;
  logic [3:0] ctrl_wdata, ctrl_rdata;
  logic [9:0] dac_code;
  logic [1:0] analog_input_sel;
  logic [10:0] analog_input_voltage [4];
  int failures, n_compared, n;
  sar_adc_and_comparator_ctrl i_dut (.clk(clk), .rst_n(rst_n), .op(op),
    .acc_in(acc_in), .ctrl_wdata(ctrl_wdata), .skip_mode_sel(skip_mode_sel),
    .comparator_out(comparator_out), .ctrl_rdata(ctrl_rdata),
    .acc_out(acc_out), .acc_out_valid(acc_out_valid), .dac_code(dac_code),
    .analog_input_sel(analog_input_sel), .adc_irq_req(adc_irq_req),
    .conversion_done_flag(conversion_done_flag),
    .skip_taken(skip_taken), .busy(busy));
  analog_front_model i_front (.analog_input_voltage(analog_input_voltage), .sel(analog_input_sel),
    .dac_code(dac_code), .comparator_out(comparator_out));
  task automatic finish_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input op_t o, input logic [7:0] a, input logic [3:0] w);
    @(posedge clk);
    op <= o;
    acc_in <= a;
    ctrl_wdata <= w;
    @(posedge clk);
    op <= '0;
    #1;
  endtask : pulse
  // Bounded wait for idle; n counts edges after the start is taken
  task automatic run;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (n >= 200) begin
      failures++;
      finish_test();
    end
  endtask : run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; op = '0; acc_in = '0; ctrl_wdata = '0; skip_mode_sel = 1'b1;
    analog_input_voltage = '{11'h3FF, 11'h2AA, 11'h155, 11'h0AA};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    pulse(OP_RD, 8'h00, 4'h0);
    chk(ctrl_rdata, 0);
    foreach (ROWS[i]) begin
      analog_input_voltage[ROWS[i].ctrl[1:0]] = ROWS[i].analog_input_voltage;
      pulse(OP_WR, 8'h00, ROWS[i].ctrl);
      pulse(OP_RD, 8'h00, 4'h0);
      chk(ctrl_rdata, ROWS[i].ctrl);
      chk(analog_input_sel, ROWS[i].ctrl[1:0]);
      pulse(OP_ST, 8'h00, 4'h0);
      run();
      chk(10'(n), 10'(CONV_CYCLES + 1));
      chk(conversion_done_flag, 1);
      pulse(OP_SK, 8'h00, 4'h0);
      chk({skip_taken, conversion_done_flag}, 2);
      pulse(OP_HI, 8'h00, 4'h0);
      hi = acc_out;
      pulse(OP_LO, 8'hFF, 4'h0);
      chk({hi.acc_b, hi.acc_a, acc_out.acc_a[3:2]}, ROWS[i].res);
    end
    $display("conversion table done");
    @(posedge clk) skip_mode_sel <= 1'b0;
    pulse(OP_ST, 8'h00, 4'h0);
    pulse(OP_ST, 8'h00, 4'h0);
    run();
    chk(10'(n), 10'(CONV_CYCLES - 1));
    chk(adc_irq_req, 1);
    pulse(OP_IQ, 8'h00, 4'h0);
    chk(conversion_done_flag, 0);
    $display("busy start and interrupt done");
    pulse(OP_WR, 8'h00, 4'hA);
    pulse(OP_LD, 8'h08, 4'h0);
    chk(dac_code, 10'h200);
    foreach (ROWS[i]) if (i < 2) begin
      analog_input_voltage[2] = i ? 11'h300 : 11'h155;
      pulse(OP_ST, 8'h00, 4'h0);
      run();
      chk(10'(n), 10'(CMP_CYCLES + 1));
      chk(conversion_done_flag, i ? 0 : 1);
      pulse(OP_IQ, 8'h00, 4'h0);
    end
    $display("comparator done");
    @(posedge clk) skip_mode_sel <= 1'b1;
    pulse(OP_WR, 8'h00, 4'h2);
    pulse(OP_SK, 8'h00, 4'h0);
    pulse(OP_LD, 8'h11, 4'h0);
    pulse(OP_WR, 8'h00, 4'hA);
    pulse(OP_HI, 8'h00, 4'h0);
    chk({acc_out.acc_b, acc_out.acc_a}, 8'h80);
    $display("mode switch done");
    pulse(OP_ST, 8'h00, 4'h0);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({busy, conversion_done_flag, analog_input_sel}, 0);
    $display("second reset done");
    finish_test();
  end
endmodule : sar_adc_and_comparator_ctrl_test
